/* logic/ump_dev_end.sv */
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Control bit 0 set drives terminal-ready low.
// - Terminal-ready high after clearing bit 0 or reset.
// - Interrupt needs bit 3, enable and condition.
// - Sources: line errors, data, empty, modem change.
// - Interrupt pins float after reset.
// - Bit 3 set: drive interrupt, user output low.
// - Bit 3 clear: float interrupt, user output high.
// - User outputs high after reset.
// - Reset clears state, idles serial pins.
// - Ring rising edge flags modem change; level readable.
// - Control bit 1 set drives request-to-send low.
// - Request-to-send high after reset.
// - Request-to-send gated only under automatic flow.
// - Loopback feeds transmit data into receiver.
// - Far end idles serial receive line high.
// - Read strobe low puts register on bus.
// - Write strobe low loads selected register.
// - Modem pulls set-ready low when ready.
// - Terminal-ready may steer an external line driver.
// - Bus bit 0 is least significant, first.
// - Host selects channel with its select line.

module ump_dev_end (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    ump_if.dev              pins,
    input  wire logic [1:0] tx_data_i,
    input  wire logic [1:0] tx_busy_i,
    input  wire logic [1:0] tx_empty_i,
    input  wire logic [1:0] rx_avail_i,
    input  wire logic [1:0] rx_err_i,
    input  wire logic [1:0] rx_hold_i,
    output logic      [1:0] rx_data_o
);

    // ************************************************************
    // Pin synchroniser
    // ************************************************************

    ump_pkg::ump_dpins_t raw;
    ump_pkg::ump_dpins_t s1_q;
    ump_pkg::ump_dpins_t s1_d;
    ump_pkg::ump_dpins_t s2_q;
    ump_pkg::ump_dpins_t s2_d;
    ump_pkg::ump_dpins_t s3_q;
    ump_pkg::ump_dpins_t s3_d;
    ump_pkg::ump_dpins_t flt_q;
    ump_pkg::ump_dpins_t flt_d;
    logic                wr_evt;
    logic                rd_end;
    logic [1:0][7:0]     rdv;
    ump_pkg::ump_chout_t cho [2];
    logic [7:0]          dout_q;
    logic [7:0]          dout_d;
    logic                doe_n_q;
    logic                doe_n_d;

    // Gather every pin that the host or modem drives.
    assign raw = '{ring_n: pins.ring_in_n, setrdy_n: pins.set_ready_n,
        ser_in: {pins.serial_in_b, pins.serial_in_a},
        cs_n: {pins.chan_b_select_n, pins.chan_a_select_n},
        rd_n: pins.read_strobe_n, wr_n: pins.write_strobe_n,
        addr: pins.addr, data: pins.data_bus};

    // A bit only changes once stages two and three agree on it.
    always_comb begin
        s1_d  = raw;
        s2_d  = s1_q;
        s3_d  = s2_q;
        flt_d = ump_pkg::ump_dpins_t'((s2_q & s3_q) |
                                      (flt_q & (s2_q | s3_q)));
    end

    // Reset parks the inputs at idle, so the receive line is ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q  <= ump_pkg::DPINS_IDLE;
            s2_q  <= ump_pkg::DPINS_IDLE;
            s3_q  <= ump_pkg::DPINS_IDLE;
            flt_q <= ump_pkg::DPINS_IDLE;
        end else if (ce_i) begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            flt_q <= flt_d;
        end
    end

    // Writes act on the falling strobe; read side effects on release.
    assign wr_evt = flt_q.wr_n & ~flt_d.wr_n;
    assign rd_end = ~flt_q.rd_n & flt_d.rd_n;

    // ************************************************************
    // Channel logic
    // ************************************************************

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [7:0]          mcr_q;
        logic [7:0]          mcr_d;
        logic [7:0]          ier_q;
        logic [7:0]          ier_d;
        logic [7:0]          efr_q;
        logic [7:0]          efr_d;
        logic [1:0]          dlt_q;
        logic [1:0]          dlt_d;
        logic [7:0]          msr_v;
        logic [7:0]          cond;
        logic [7:0]          rd_v;
        logic                sel;
        logic                set_chg;
        logic                ring_end;
        ump_pkg::ump_chout_t out_q;
        ump_pkg::ump_chout_t out_d;

        // Register writes, status deltas, read mux and pin levels.
        always_comb begin
            sel      = ~flt_d.cs_n[c];
            set_chg  = flt_q.setrdy_n[c] ^ flt_d.setrdy_n[c];
            ring_end = ~flt_q.ring_n[c] & flt_d.ring_n[c];
            mcr_d = mcr_q;
            ier_d = ier_q;
            efr_d = efr_q;
            if (wr_evt && sel) begin
                case (flt_d.addr)
                    ump_pkg::REG_IER: ier_d = flt_d.data;
                    ump_pkg::REG_EFR: efr_d = flt_d.data;
                    ump_pkg::REG_MCR: mcr_d = flt_d.data;
                    default: ;
                endcase
            end
            // Reading status clears the deltas; a new event still wins.
            dlt_d = dlt_q;
            if (rd_end && sel && flt_d.addr == ump_pkg::REG_MSR) begin
                dlt_d = 2'h0;
            end
            dlt_d = dlt_d | {ring_end, set_chg};
            msr_v = 8'h00;
            msr_v[ump_pkg::MSR_DSETRDY] = dlt_q[0];
            msr_v[ump_pkg::MSR_TRING]   = dlt_q[1];
            msr_v[ump_pkg::MSR_SETRDY]  = ~flt_q.setrdy_n[c];
            msr_v[ump_pkg::MSR_RING]    = ~flt_q.ring_n[c];
            cond = 8'h00;
            cond[ump_pkg::IER_RXAV]  = rx_avail_i[c];
            cond[ump_pkg::IER_TXEMP] = tx_empty_i[c];
            cond[ump_pkg::IER_RXERR] = rx_err_i[c];
            cond[ump_pkg::IER_MODEM] = |dlt_q;
            case (flt_d.addr)
                ump_pkg::REG_IER: rd_v = ier_q;
                ump_pkg::REG_EFR: rd_v = efr_q;
                ump_pkg::REG_MCR: rd_v = mcr_q;
                ump_pkg::REG_MSR: rd_v = msr_v;
                default:          rd_v = 8'h00;
            endcase
            out_d.irq      = mcr_q[ump_pkg::MCR_IRQEN] &
                             (|(ier_q & cond));
            out_d.irq_oe_n = ~mcr_q[ump_pkg::MCR_IRQEN];
            out_d.user_n   = ~mcr_q[ump_pkg::MCR_IRQEN];
            // In line-driver mode the pin enables the external driver.
            out_d.tready_n = efr_q[ump_pkg::EFR_RS485] ? ~tx_busy_i[c]
                : ~mcr_q[ump_pkg::MCR_TREADY];
            out_d.rsend_n  = ~(mcr_q[ump_pkg::MCR_RSEND] &
                ~(efr_q[ump_pkg::EFR_AUTORS] & rx_hold_i[c]));
            // Loopback keeps the line at mark so the far end sees idle.
            out_d.tx = mcr_q[ump_pkg::MCR_LOOP] | tx_data_i[c];
            out_d.rx = mcr_q[ump_pkg::MCR_LOOP] ? tx_data_i[c]
                : flt_q.ser_in[c];
        end

        // Channel registers.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mcr_q <= ump_pkg::RST_BYTE;
                ier_q <= ump_pkg::RST_BYTE;
                efr_q <= ump_pkg::RST_BYTE;
                dlt_q <= 2'h0;
                out_q <= ump_pkg::CHOUT_RST;
            end else if (ce_i) begin
                mcr_q <= mcr_d;
                ier_q <= ier_d;
                efr_q <= efr_d;
                dlt_q <= dlt_d;
                out_q <= out_d;
            end
        end

        assign rdv[c]       = rd_v;
        assign cho[c]       = out_q;
        assign rx_data_o[c] = out_q.rx;
    end

    // ************************************************************
    // Shared data bus
    // ************************************************************

    // Channel A wins if a careless host selects both at once.
    always_comb begin
        doe_n_d = flt_d.rd_n | (&flt_d.cs_n);
        dout_d  = !flt_d.cs_n[0] ? rdv[0] : rdv[1];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_q  <= ump_pkg::RST_BYTE;
            doe_n_q <= 1'b1;
        end else if (ce_i) begin
            dout_q  <= dout_d;
            doe_n_q <= doe_n_d;
        end
    end

    // Pin outputs, each straight from a flip-flop.
    assign pins.ddata           = dout_q;
    assign pins.ddata_oe_n      = doe_n_q;
    assign pins.irq_chan_a      = cho[0].irq;
    assign pins.irq_chan_a_oe_n = cho[0].irq_oe_n;
    assign pins.irq_chan_b      = cho[1].irq;
    assign pins.irq_chan_b_oe_n = cho[1].irq_oe_n;
    assign pins.term_ready_n    = {cho[1].tready_n, cho[0].tready_n};
    assign pins.req_send_n      = {cho[1].rsend_n, cho[0].rsend_n};
    assign pins.user_out_n      = {cho[1].user_n, cho[0].user_n};
    assign pins.tx_line         = {cho[1].tx, cho[0].tx};

endmodule : ump_dev_end

`default_nettype wire

/* logic/ump_host_end.sv */
`timescale 1ns/10ps
`default_nettype none

module ump_host_end (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    ump_if.host              pins
);

    // ************************************************************
    // Pin synchroniser
    // ************************************************************

    ump_pkg::ump_hpins_t raw;
    ump_pkg::ump_hpins_t s1_q;
    ump_pkg::ump_hpins_t s2_q;
    ump_pkg::ump_hpins_t s3_q;
    ump_pkg::ump_hpins_t flt_q;
    ump_pkg::ump_hpins_t flt_d;

    assign raw = '{data: pins.data_bus, irq: pins.irq_line,
        user_n: pins.user_out_n, rsend_n: pins.req_send_n,
        tready_n: pins.term_ready_n, tx: pins.tx_line};

    // A bit only changes once stages two and three agree on it.
    always_comb begin
        flt_d = ump_pkg::ump_hpins_t'((s2_q & s3_q) |
                                      (flt_q & (s2_q | s3_q)));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q  <= ump_pkg::HPINS_IDLE;
            s2_q  <= ump_pkg::HPINS_IDLE;
            s3_q  <= ump_pkg::HPINS_IDLE;
            flt_q <= ump_pkg::HPINS_IDLE;
        end else if (ce_i) begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end

    // ************************************************************
    // Bus slave and pin sequencer
    // ************************************************************

    ump_pkg::ump_hstate_t st_q;
    ump_pkg::ump_hstate_t st_d;
    ump_pkg::ump_modem_t  mdm_q;
    ump_pkg::ump_modem_t  mdm_d;
    logic [3:0]           cnt_q;
    logic [3:0]           cnt_d;
    logic                 ack_q;
    logic                 ack_d;
    logic [31:0]          dat_q;
    logic [31:0]          dat_d;
    logic [2:0]           addr_q;
    logic [2:0]           addr_d;
    logic [7:0]           hdat_q;
    logic [7:0]           hdat_d;
    logic                 hoe_n_q;
    logic                 hoe_n_d;
    logic                 rd_n_q;
    logic                 rd_n_d;
    logic                 wr_n_q;
    logic                 wr_n_d;
    logic [1:0]           cs_n_q;
    logic [1:0]           cs_n_d;
    logic                 rdop_q;
    logic                 rdop_d;
    logic [7:0]           last_q;
    logic [7:0]           last_d;
    logic                 req;
    logic [31:0]          stat;

    // A command write is answered only after its whole pin cycle.
    always_comb begin
        req  = wb_cyc_i & wb_stb_i & ~ack_q;
        stat = 32'({flt_q.irq, flt_q.user_n, flt_q.rsend_n,
                    flt_q.tready_n, flt_q.tx, last_q});
        st_d = st_q;
        mdm_d = mdm_q;
        cnt_d = cnt_q;
        ack_d = 1'b0;
        dat_d = dat_q;
        addr_d = addr_q;
        hdat_d = hdat_q;
        hoe_n_d = hoe_n_q;
        rd_n_d = rd_n_q;
        wr_n_d = wr_n_q;
        cs_n_d = cs_n_q;
        rdop_d = rdop_q;
        last_d = last_q;
        case (st_q)
            ump_pkg::H_IDLE: begin
                if (req && wb_we_i && wb_adr_i == ump_pkg::WB_CMD) begin
                    addr_d  = wb_dat_i[ump_pkg::CMD_ADDR_LSB +: 3];
                    hdat_d  = wb_dat_i[7:0];
                    rdop_d  = wb_dat_i[ump_pkg::CMD_READ];
                    hoe_n_d = wb_dat_i[ump_pkg::CMD_READ];
                    cs_n_d  = wb_dat_i[ump_pkg::CMD_CHAN] ? 2'h1 : 2'h2;
                    cnt_d   = 4'(ump_pkg::SETUP_CYC - 1);
                    st_d    = ump_pkg::H_SETUP;
                end else if (req) begin
                    ack_d = 1'b1;
                    case (wb_adr_i)
                        ump_pkg::WB_STAT:  dat_d = stat;
                        ump_pkg::WB_MODEM: dat_d = 32'(mdm_q);
                        default:           dat_d = 32'h00000000;
                    endcase
                    if (wb_we_i && wb_adr_i == ump_pkg::WB_MODEM &&
                        wb_sel_i[0]) begin
                        mdm_d = wb_dat_i[$bits(mdm_q)-1:0];
                    end
                end
            end
            ump_pkg::H_SETUP: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    rd_n_d = ~rdop_q;
                    wr_n_d = rdop_q;
                    cnt_d  = 4'(ump_pkg::STROBE_CYC - 1);
                    st_d   = ump_pkg::H_STROBE;
                end
            end
            ump_pkg::H_STROBE: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    if (rdop_q) begin
                        last_d = flt_q.data;
                    end
                    rd_n_d = 1'b1;
                    wr_n_d = 1'b1;
                    cnt_d  = 4'(ump_pkg::HOLD_CYC - 1);
                    st_d   = ump_pkg::H_HOLD;
                end
            end
            ump_pkg::H_HOLD: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h0) begin
                    cs_n_d  = 2'h3;
                    hoe_n_d = 1'b1;
                    ack_d   = 1'b1;
                    dat_d   = 32'(last_q);
                    st_d    = ump_pkg::H_IDLE;
                end
            end
            default: st_d = ump_pkg::H_IDLE;
        endcase
    end

    // Idle serial line stays high until software changes it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= ump_pkg::H_IDLE;
            mdm_q   <= ump_pkg::MODEM_RST;
            cnt_q   <= 4'h0;
            ack_q   <= 1'b0;
            dat_q   <= 32'h00000000;
            addr_q  <= 3'h0;
            hdat_q  <= 8'h00;
            hoe_n_q <= 1'b1;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            cs_n_q  <= 2'h3;
            rdop_q  <= 1'b0;
            last_q  <= 8'h00;
        end else if (ce_i) begin
            st_q    <= st_d;
            mdm_q   <= mdm_d;
            cnt_q   <= cnt_d;
            ack_q   <= ack_d;
            dat_q   <= dat_d;
            addr_q  <= addr_d;
            hdat_q  <= hdat_d;
            hoe_n_q <= hoe_n_d;
            rd_n_q  <= rd_n_d;
            wr_n_q  <= wr_n_d;
            cs_n_q  <= cs_n_d;
            rdop_q  <= rdop_d;
            last_q  <= last_d;
        end
    end

    assign wb_dat_o             = dat_q;
    assign wb_ack_o             = ack_q;
    assign pins.addr            = addr_q;
    assign pins.hdata           = hdat_q;
    assign pins.hdata_oe_n      = hoe_n_q;
    assign pins.read_strobe_n   = rd_n_q;
    assign pins.write_strobe_n  = wr_n_q;
    assign pins.chan_a_select_n = cs_n_q[0];
    assign pins.chan_b_select_n = cs_n_q[1];
    assign pins.ring_in_n       = mdm_q.ring_n;
    assign pins.set_ready_n     = mdm_q.setrdy_n;
    assign pins.serial_in_a     = mdm_q.ser[0];
    assign pins.serial_in_b     = mdm_q.ser[1];

endmodule : ump_host_end

`default_nettype wire

/* logic/ump_if.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Pins between the processor side and the dual serial device
// ****************************************************************

interface ump_if;
    logic [2:0] addr;
    logic [7:0] hdata;
    logic       hdata_oe_n;
    logic [7:0] ddata;
    logic       ddata_oe_n;
    logic [7:0] data_bus;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic       chan_a_select_n;
    logic       chan_b_select_n;
    logic       irq_chan_a;
    logic       irq_chan_a_oe_n;
    logic       irq_chan_b;
    logic       irq_chan_b_oe_n;
    logic [1:0] irq_line;
    logic [1:0] term_ready_n;
    logic [1:0] req_send_n;
    logic [1:0] user_out_n;
    logic [1:0] tx_line;
    logic [1:0] ring_in_n;
    logic [1:0] set_ready_n;
    logic       serial_in_a;
    logic       serial_in_b;

    // Resolve the shared data bus; an undriven bus floats high.
    assign data_bus = !ddata_oe_n ? ddata :
                      (!hdata_oe_n ? hdata : 8'hFF);

    // Interrupt lines in high impedance read low, as if pulled down.
    assign irq_line[0] = irq_chan_a_oe_n ? 1'b0 : irq_chan_a;
    assign irq_line[1] = irq_chan_b_oe_n ? 1'b0 : irq_chan_b;

    modport dev (
        input  addr, data_bus, read_strobe_n, write_strobe_n,
        input  chan_a_select_n, chan_b_select_n, ring_in_n,
        input  set_ready_n, serial_in_a, serial_in_b,
        output ddata, ddata_oe_n, irq_chan_a, irq_chan_a_oe_n,
        output irq_chan_b, irq_chan_b_oe_n, term_ready_n, req_send_n,
        output user_out_n, tx_line
    );

    modport host (
        output addr, hdata, hdata_oe_n, read_strobe_n, write_strobe_n,
        output chan_a_select_n, chan_b_select_n, ring_in_n,
        output set_ready_n, serial_in_a, serial_in_b,
        input  data_bus, irq_line, term_ready_n, req_send_n,
        input  user_out_n, tx_line
    );
endinterface : ump_if

`default_nettype wire

/* logic/ump_pkg.sv */
`default_nettype none

// ****************************************************************
// Shared constants and types of the modem-pin block
// ****************************************************************

package ump_pkg;

    // Clock period and pin-cycle timing of the host end.
    localparam int CLK_NS     = 8;
    localparam int SETUP_NS   = 16;
    localparam int STROBE_NS  = 96;
    localparam int HOLD_NS    = 16;
    localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;

    // Device register addresses on the three address pins.
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_EFR = 3'h2;
    localparam logic [2:0] REG_MCR = 3'h4;
    localparam logic [2:0] REG_MSR = 3'h6;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Bit positions inside the device registers.
    localparam int MCR_TREADY  = 0;
    localparam int MCR_RSEND   = 1;
    localparam int MCR_IRQEN   = 3;
    localparam int MCR_LOOP    = 4;
    localparam int EFR_RS485   = 5;
    localparam int EFR_AUTORS  = 6;
    localparam int IER_RXAV    = 0;
    localparam int IER_TXEMP   = 1;
    localparam int IER_RXERR   = 2;
    localparam int IER_MODEM   = 3;
    localparam int MSR_DSETRDY = 1;
    localparam int MSR_TRING   = 2;
    localparam int MSR_SETRDY  = 5;
    localparam int MSR_RING    = 6;

    // Pins seen by the device, passed through its synchroniser.
    typedef struct packed {
        logic [1:0] ring_n;
        logic [1:0] setrdy_n;
        logic [1:0] ser_in;
        logic [1:0] cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } ump_dpins_t;
    localparam ump_dpins_t DPINS_IDLE = '{ring_n: 2'h3, setrdy_n: 2'h3,
        ser_in: 2'h3, cs_n: 2'h3, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0,
        data: 8'h00};

    // Per-channel pin outputs of the device.
    typedef struct packed {
        logic irq;
        logic irq_oe_n;
        logic user_n;
        logic tready_n;
        logic rsend_n;
        logic tx;
        logic rx;
    } ump_chout_t;
    localparam ump_chout_t CHOUT_RST = '{irq: 1'b0, irq_oe_n: 1'b1,
        user_n: 1'b1, tready_n: 1'b1, rsend_n: 1'b1, tx: 1'b1, rx: 1'b1};

    // Pins seen by the host, passed through its synchroniser.
    typedef struct packed {
        logic [7:0] data;
        logic [1:0] irq;
        logic [1:0] user_n;
        logic [1:0] rsend_n;
        logic [1:0] tready_n;
        logic [1:0] tx;
    } ump_hpins_t;
    localparam ump_hpins_t HPINS_IDLE = '{data: 8'h00, irq: 2'h0,
        user_n: 2'h3, rsend_n: 2'h3, tready_n: 2'h3, tx: 2'h3};

    // Modem-side levels that the host end drives.
    typedef struct packed {
        logic [1:0] ser;
        logic [1:0] setrdy_n;
        logic [1:0] ring_n;
    } ump_modem_t;
    localparam ump_modem_t MODEM_RST = '{ser: 2'h3, setrdy_n: 2'h3,
        ring_n: 2'h3};

    // Wishbone register map of the host end.
    localparam logic [3:0] WB_CMD   = 4'h0;
    localparam logic [3:0] WB_STAT  = 4'h4;
    localparam logic [3:0] WB_MODEM = 4'h8;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_CHAN     = 12;
    localparam int CMD_READ     = 16;

    typedef enum logic [1:0] {
        H_IDLE,
        H_SETUP,
        H_STROBE,
        H_HOLD
    } ump_hstate_t;

endpackage : ump_pkg

`default_nettype wire

/* verification/uart_modem_control_pins_test.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench of both link ends.
// ****
module uart_modem_control_pins_test;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wd = 32'h0, rd, r;
    logic        ack;
    logic [1:0]  txd = 2'h3, av = 2'h0, em = 2'h0, er = 2'h0, hd = 2'h0, rxd;
    int          n_errors = 0, check_count = 0;
    ump_if u_ump_if ();
    ump_dev_end u_ump_dev_end (.clk_i, .rst_i, .ce_i(1'b1), .pins(u_ump_if),
        .tx_data_i(txd), .tx_busy_i(2'h0), .tx_empty_i(em), .rx_avail_i(av),
        .rx_err_i(er), .rx_hold_i(hd), .rx_data_o(rxd));
    ump_host_end u_ump_host_end (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .pins(u_ump_if));
    ump_checker u_ump_checker (.clk_i, .rst_i, .addr(u_ump_if.addr),
        .data_bus(u_ump_if.data_bus), .read_strobe_n(u_ump_if.read_strobe_n),
        .write_strobe_n(u_ump_if.write_strobe_n),
        .chan_a_select_n(u_ump_if.chan_a_select_n),
        .chan_b_select_n(u_ump_if.chan_b_select_n),
        .ddata_oe_n(u_ump_if.ddata_oe_n),
        .irq_chan_a_oe_n(u_ump_if.irq_chan_a_oe_n),
        .irq_chan_b_oe_n(u_ump_if.irq_chan_b_oe_n),
        .irq_line(u_ump_if.irq_line), .term_ready_n(u_ump_if.term_ready_n),
        .req_send_n(u_ump_if.req_send_n), .user_out_n(u_ump_if.user_out_n));
    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wd} <= {2'h3, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rd;
        {cyc, stb} <= 2'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic dv(input logic c, q, input logic [2:0] a, input logic [7:0] d);
        wb(1'b1, ump_pkg::WB_CMD, {15'h0, q, 3'h0, c, 1'b0, a, d});
    endtask : dv
    task automatic t_reset();
        chk({u_ump_if.term_ready_n, u_ump_if.req_send_n, u_ump_if.user_out_n,
            u_ump_if.irq_line, u_ump_if.tx_line}, 10'h3F3);
        wb(1'b0, 4'hC, 32'h0);
        chk(r, 32'h0);
    endtask : t_reset
    task automatic t_mcr();
        dv(1'b0, 1'b0, ump_pkg::REG_MCR, 8'h0B);
        chk({u_ump_if.term_ready_n, u_ump_if.req_send_n, u_ump_if.user_out_n},
            6'h2A);
        dv(1'b0, 1'b1, ump_pkg::REG_MCR, 8'h00);
        chk(r[7:0], 8'h0B);
        for (int i = 0; i < 3; i++) begin
            {av, em, er} <= {1'b0, i == 0, 1'b0, i == 1, 1'b0, i == 2};
            dv(1'b0, 1'b0, ump_pkg::REG_IER, 8'h01 << i);
            chk(u_ump_if.irq_line, 2'h1);
        end
        dv(1'b0, 1'b0, ump_pkg::REG_MCR, 8'h00);
        chk({u_ump_if.irq_line, u_ump_if.user_out_n}, 4'h3);
        dv(1'b1, 1'b0, ump_pkg::REG_MCR, 8'h01);
        chk(u_ump_if.term_ready_n, 2'h1);
    endtask : t_mcr
    task automatic t_ring();
        dv(1'b0, 1'b0, ump_pkg::REG_MCR, 8'h08);
        dv(1'b0, 1'b0, ump_pkg::REG_IER, 8'h08);
        wb(1'b1, ump_pkg::WB_MODEM, 32'h3E);
        dv(1'b0, 1'b1, ump_pkg::REG_MSR, 8'h00);
        chk({u_ump_if.irq_line, r[7:0]}, 10'h040);
        wb(1'b1, ump_pkg::WB_MODEM, 32'h3B);
        repeat (8) @(posedge clk_i);
        chk(u_ump_if.irq_line, 2'h1);
        dv(1'b0, 1'b1, ump_pkg::REG_MSR, 8'h00);
        chk(r[7:0], 8'h26);
        wb(1'b1, ump_pkg::WB_MODEM, 32'h2F);
    endtask : t_ring
    task automatic t_loop();
        dv(1'b0, 1'b0, ump_pkg::REG_MCR, 8'h10);
        txd <= 2'h1;
        repeat (8) @(posedge clk_i);
        chk({rxd[0], u_ump_if.tx_line[0]}, 2'h3);
        dv(1'b0, 1'b0, ump_pkg::REG_MCR, 8'h00);
        chk({rxd[0], u_ump_if.tx_line[0]}, 2'h1);
        wb(1'b1, ump_pkg::WB_MODEM, 32'h3F);
    endtask : t_loop
    task automatic t_flow();
        dv(1'b0, 1'b0, ump_pkg::REG_EFR, 8'h40);
        dv(1'b0, 1'b0, ump_pkg::REG_MCR, 8'h02);
        hd <= 2'h1;
        repeat (8) @(posedge clk_i);
        chk(u_ump_if.req_send_n, 2'h3);
        hd <= 2'h0;
        repeat (8) @(posedge clk_i);
        chk(u_ump_if.req_send_n, 2'h2);
    endtask : t_flow
    task automatic close_out();
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    // Run after ten reset cycles.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mcr();
        t_ring();
        t_loop();
        t_flow();
        close_out();
    end
    // Watchdog far past the tests.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        close_out();
    end
endmodule : uart_modem_control_pins_test
`default_nettype wire

/* verification/ump_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Pin checks across the link.
// ****
module ump_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [2:0] addr,
    input wire logic [7:0] data_bus,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       chan_a_select_n,
    input wire logic       chan_b_select_n,
    input wire logic       ddata_oe_n,
    input wire logic       irq_chan_a_oe_n,
    input wire logic       irq_chan_b_oe_n,
    input wire logic [1:0] irq_line,
    input wire logic [1:0] term_ready_n,
    input wire logic [1:0] req_send_n,
    input wire logic [1:0] user_out_n
);
    logic wr_q;
    logic wr_d;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // First low cycle of a control write.
    always_comb wr_d = write_strobe_n;
    always_ff @(posedge clk_i) wr_q <= wr_d;
    wire logic mw = wr_q && !write_strobe_n && addr == ump_pkg::REG_MCR;
    // 7 back still sees the write data.
    a_reset_pins: assert property ($fell(rst_i) |->
        {term_ready_n, req_send_n, user_out_n, irq_line} == 8'hFC)
        else $error("reset pins");
    a_user_irq_a: assert property (user_out_n[0] == irq_chan_a_oe_n)
        else $error("user/irq A");
    a_user_irq_b: assert property (user_out_n[1] == irq_chan_b_oe_n)
        else $error("user/irq B");
    a_irq_gate: assert property (irq_line[0] |-> !user_out_n[0])
        else $error("irq gate");
    a_tready_wr: assert property (mw && !chan_a_select_n |->
        ##7 term_ready_n[0] == !$past(data_bus[0], 7))
        else $error("tready A");
    a_rsend_wr: assert property (mw && !chan_a_select_n |->
        ##7 req_send_n[0] == !$past(data_bus[1], 7))
        else $error("rsend A");
    a_tready_b: assert property (mw && !chan_b_select_n |->
        ##7 term_ready_n[1] == !$past(data_bus[0], 7))
        else $error("tready B");
    a_read_drive: assert property ($fell(ddata_oe_n) |->
        $past(read_strobe_n, 3) == 1'b0)
        else $error("read drive");
endmodule : ump_checker
`default_nettype wire
